/* File: design/fvic_controller.v */
// Four-vector interrupt controller: flags, enables, priority and vectoring.
// Assumes one instruction clock shared with the core sequencer and sources;
// source strobes other than the two pins are synchronous one-cycle pulses.
//
// Summary of operation
// - Status bit 7 reads OR of peripheral flags masked by peripheral enables.
// - Every flag sets on its event regardless of enables or global disable.
// - Flag set in the cycle its status enable is cleared, globally enabled, core ready: branch to reset.
// - Bit 6 sets on timer clock pin edge, clears on vector 18h.
// - Bit 5 sets on timer zero overflow, clears on vector 10h.
// - Bit 4 sets on external pin edge, clears on vector 08h.
// - Status bits 3..0: group, timer clock, timer zero, external enables.
// - Peripheral enables 7..0: port, t3, t2, t1, cap2, cap1, tx, rx.
// - Peripheral flags use the same bit order as the enables.
// - Port change sets flag; software must end the mismatch first.
// - Timer three flag: overflow with capture one, else period rollover.
// - Timer two flag sets on rollover to zero from its period.
// - Timer one flag: 8-bit period rollover or 16-bit pair rollover.
// - Capture flags set on capture; tx reads empty, rx reads full.
// - Global disable blocks all interrupts; set by reset.
// - Peripheral request needs both group enable and own enable.
// - Acceptance sets global disable, pushes return address, loads vector.
// - Return instruction pops and clears global disable together.
// - Priority: external, timer zero, timer clock pin, peripherals.
// - External pin edge: rising when select set, falling when clear.
// - Timer clock pin edge: rising when select set, falling when clear.
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`include "fvic_map.vh"
module fvic_controller (
    // Clock and reset
    input wire clock,
    input wire reset_n,
    // Register port
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdData_q,
    // Request pins and edge selects
    input wire extIrqPin,
    input wire timerClockPin,
    input wire extPinEdgeSelect,
    input wire timerClockEdgeSelect,
    // Timer and capture event strobes and mode selects
    input wire timerZeroOverflow,
    input wire timerOneRollover8,
    input wire timerOneTwoRollover16,
    input wire timerOneWideMode,
    input wire timerTwoRollover,
    input wire timerThreeOverflow,
    input wire timerThreePeriodRollover,
    input wire captureOneSelect,
    input wire captureOneEvent,
    input wire captureTwoEvent,
    // Port and serial status
    input wire portMismatch,
    input wire transmitEmpty,
    input wire receiveFull,
    // Core sequencer
    input wire coreAcceptReady,
    input wire returnFromIrq,
    output reg irqTake_q,
    output reg [15:0] vectorAddr_q,
    output reg pushReturn_q,
    output reg popReturn_q,
    output reg globalIrqDisable_q
);
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_TAKE = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg tclkFlag_q;
    reg tzeroFlag_q;
    reg extFlag_q;
    reg [3:0] statusEn_q;
    reg [7:0] pFlags_q;
    reg [7:0] pEnables_q;
    reg [15:0] vec_d;
    reg clrExt;
    reg clrTzero;
    reg clrTclk;
    wire extEdge;
    wire tclkEdge;
    wire groupFlag;
    wire [7:0] pEvents;
    wire [7:0] pNext;
    wire [3:0] pending;
    wire [3:0] enNew;
    wire wrStatus;
    wire wrPFlags;
    wire wrPEnables;
    wire wrCore;
    wire raceHit;
    wire [7:0] statusRead;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    fvic_edge_sync extSync (
        .clock(clock),
        .reset_n(reset_n),
        .pinIn(extIrqPin),
        .risingSel(extPinEdgeSelect),
        .edgeSeen_q(extEdge)
    );

    fvic_edge_sync tclkSync (
        .clock(clock),
        .reset_n(reset_n),
        .pinIn(timerClockPin),
        .risingSel(timerClockEdgeSelect),
        .edgeSeen_q(tclkEdge)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign wrStatus = regWrite & (regAddr == `FVIC_OFF_STATUS);
    assign wrPFlags = regWrite & (regAddr == `FVIC_OFF_PFLAGS);
    assign wrPEnables = regWrite & (regAddr == `FVIC_OFF_PENABLES);
    assign wrCore = regWrite & (regAddr == `FVIC_OFF_CORE);

    // Peripheral events
    // Port mismatch is a level: as long as it stands the flag re-sets
    assign pEvents[`FVIC_BIT_PC_PORT] = portMismatch;
    assign pEvents[`FVIC_BIT_PC_T3] = captureOneSelect ? timerThreeOverflow
                                                       : timerThreePeriodRollover;
    assign pEvents[`FVIC_BIT_PC_T2] = timerTwoRollover;
    assign pEvents[`FVIC_BIT_PC_T1] = timerOneWideMode ? timerOneTwoRollover16
                                                       : timerOneRollover8;
    assign pEvents[`FVIC_BIT_PC_CAP2] = captureTwoEvent;
    assign pEvents[`FVIC_BIT_PC_CAP1] = captureOneEvent;
    assign pEvents[`FVIC_BIT_PC_TX] = 1'b0;
    assign pEvents[`FVIC_BIT_PC_RX] = 1'b0;

    // Set wins over a software clear; serial bits follow their buffer state
    assign pNext = {(wrPFlags ? regWrData[7:2] : pFlags_q[7:2]) | pEvents[7:2],
                    transmitEmpty, receiveFull};

    assign groupFlag = |(pFlags_q & pEnables_q);
    assign statusRead = {groupFlag, tclkFlag_q, tzeroFlag_q, extFlag_q, statusEn_q};

    // Requests that may reach the core
    assign pending[3] = extFlag_q & statusEn_q[`FVIC_BIT_EXT_EN];
    assign pending[2] = tzeroFlag_q & statusEn_q[`FVIC_BIT_TZERO_EN];
    assign pending[1] = tclkFlag_q & statusEn_q[`FVIC_BIT_TCLK_EN];
    assign pending[0] = groupFlag & statusEn_q[`FVIC_BIT_GROUP_EN];

    // An enable dropped in the cycle its flag rises, while enabled globally
    assign enNew = regWrData[3:0];
    assign raceHit = wrStatus & ~globalIrqDisable_q & (
        (extEdge & statusEn_q[`FVIC_BIT_EXT_EN] & ~enNew[`FVIC_BIT_EXT_EN]) |
        (timerZeroOverflow & statusEn_q[`FVIC_BIT_TZERO_EN] & ~enNew[`FVIC_BIT_TZERO_EN]) |
        (tclkEdge & statusEn_q[`FVIC_BIT_TCLK_EN] & ~enNew[`FVIC_BIT_TCLK_EN]) |
        ((|(pEvents & pEnables_q)) & statusEn_q[`FVIC_BIT_GROUP_EN] &
         ~enNew[`FVIC_BIT_GROUP_EN]));

    // ------------------------------------------------------------
    // Priority and sequencing
    // ------------------------------------------------------------
    always @* begin
        state_d = state_q;
        vec_d = `FVIC_VEC_PERIPH;
        clrExt = 1'b0;
        clrTzero = 1'b0;
        clrTclk = 1'b0;
        if (pending[3]) begin
            vec_d = `FVIC_VEC_EXT;
            clrExt = 1'b1;
        end else if (pending[2]) begin
            vec_d = `FVIC_VEC_TZERO;
            clrTzero = 1'b1;
        end else if (pending[1]) begin
            vec_d = `FVIC_VEC_TCLK;
            clrTclk = 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                if ((raceHit | (|pending)) & ~globalIrqDisable_q & coreAcceptReady) begin
                    state_d = ST_TAKE;
                end
            end
            ST_TAKE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Only a real take may clear flags
        if (!((state_q == ST_IDLE) && (state_d == ST_TAKE) && !raceHit)) begin
            clrExt = 1'b0;
            clrTzero = 1'b0;
            clrTclk = 1'b0;
        end
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            irqTake_q <= 1'b0;
            pushReturn_q <= 1'b0;
            popReturn_q <= 1'b0;
            vectorAddr_q <= `FVIC_VEC_RESET;
            globalIrqDisable_q <= 1'b1;
        end else begin
            state_q <= state_d;
            popReturn_q <= returnFromIrq;
            if ((state_q == ST_IDLE) && (state_d == ST_TAKE)) begin
                irqTake_q <= 1'b1;
                pushReturn_q <= ~raceHit;
                vectorAddr_q <= raceHit ? `FVIC_VEC_RESET : vec_d;
                globalIrqDisable_q <= 1'b1;
            end else begin
                irqTake_q <= 1'b0;
                pushReturn_q <= 1'b0;
                if (returnFromIrq) begin
                    globalIrqDisable_q <= 1'b0;
                end else if (wrCore) begin
                    globalIrqDisable_q <= regWrData[`FVIC_BIT_GLOBAL_DIS];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            statusEn_q <= 4'h0;
            extFlag_q <= 1'b0;
            tzeroFlag_q <= 1'b0;
            tclkFlag_q <= 1'b0;
            pFlags_q <= `FVIC_PFLAGS_RESET;
            pEnables_q <= `FVIC_PENABLES_RESET;
            regRdData_q <= 8'h00;
        end else begin
            if (wrStatus) begin
                statusEn_q <= regWrData[3:0];
            end
            if (wrPEnables) begin
                pEnables_q <= regWrData;
            end
            pFlags_q <= pNext;
            // Event beats both software write and vector clear
            extFlag_q <= extEdge |
                (~clrExt & (wrStatus ? regWrData[`FVIC_BIT_EXT_FLAG] : extFlag_q));
            tzeroFlag_q <= timerZeroOverflow |
                (~clrTzero & (wrStatus ? regWrData[`FVIC_BIT_TZERO_FLAG] : tzeroFlag_q));
            tclkFlag_q <= tclkEdge |
                (~clrTclk & (wrStatus ? regWrData[`FVIC_BIT_TCLK_FLAG] : tclkFlag_q));
            if (regRead) begin
                case (regAddr)
                    `FVIC_OFF_STATUS: regRdData_q <= statusRead;
                    `FVIC_OFF_PFLAGS: regRdData_q <= pFlags_q;
                    `FVIC_OFF_PENABLES: regRdData_q <= pEnables_q;
                    `FVIC_OFF_CORE: regRdData_q <= {3'b000, globalIrqDisable_q, 4'h0};
                    default: regRdData_q <= 8'h00;
                endcase
            end else begin
                regRdData_q <= 8'h00;
            end
        end
    end
endmodule

/* File: common/fvic_map.vh */
// Constants for the four-vector interrupt controller: offsets, bits, vectors.
// Included by the controller design; holds definitions only.
`ifndef FVIC_MAP_VH
`define FVIC_MAP_VH
`define FVIC_ADDR_W 8
`define FVIC_OFF_STATUS 8'h07
`define FVIC_OFF_PFLAGS 8'h16
`define FVIC_OFF_PENABLES 8'h17
`define FVIC_OFF_CORE 8'h06
`define FVIC_BIT_GROUP_FLAG 7
`define FVIC_BIT_TCLK_FLAG 6
`define FVIC_BIT_TZERO_FLAG 5
`define FVIC_BIT_EXT_FLAG 4
`define FVIC_BIT_GROUP_EN 3
`define FVIC_BIT_TCLK_EN 2
`define FVIC_BIT_TZERO_EN 1
`define FVIC_BIT_EXT_EN 0
`define FVIC_BIT_GLOBAL_DIS 4
`define FVIC_BIT_PC_PORT 7
`define FVIC_BIT_PC_T3 6
`define FVIC_BIT_PC_T2 5
`define FVIC_BIT_PC_T1 4
`define FVIC_BIT_PC_CAP2 3
`define FVIC_BIT_PC_CAP1 2
`define FVIC_BIT_PC_TX 1
`define FVIC_BIT_PC_RX 0
`define FVIC_STATUS_RESET 8'h00
`define FVIC_PFLAGS_RESET 8'h00
`define FVIC_PENABLES_RESET 8'h00
`define FVIC_VEC_RESET 16'h0000
`define FVIC_VEC_EXT 16'h0008
`define FVIC_VEC_TZERO 16'h0010
`define FVIC_VEC_TCLK 16'h0018
`define FVIC_VEC_PERIPH 16'h0020
`endif

/* File: design/fvic_edge_sync.v */
// Pin synchroniser with selectable edge detector, one per request pin.
// Assumes the pin is asynchronous to clock; risingSel is a register on clock.
`timescale 1ns/10ps
module fvic_edge_sync (
    // Clock and reset
    input wire clock,
    input wire reset_n,
    // Pin and edge choice
    input wire pinIn,
    input wire risingSel,
    // Result
    output reg edgeSeen_q
);
    reg meta_q;
    reg sync_q;
    reg last_q;
    reg [1:0] fill_q;

    // Only the second stage and later are looked at
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            fill_q <= 2'h0;
            edgeSeen_q <= 1'b0;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            last_q <= sync_q;
            // Pipe holds reset zeros until filled; a high idle pin must not look like an edge
            if (fill_q != 2'h3) begin
                fill_q <= fill_q + 2'h1;
            end
            edgeSeen_q <= (fill_q == 2'h3) &
                (risingSel ? (sync_q & ~last_q) : (~sync_q & last_q));
        end
    end
endmodule

/* File: bench/fvic_core_model.sv */
// Core sequencer stand-in: grants acceptance and runs the return instruction.
// Assumes the controller clock; doRet is a one-cycle request from the bench.
`timescale 1ns/10ps
module fvic_core_model (
    // Clock and reset
    input wire clock,
    input wire reset_n,
    // Bench controls
    input wire slow,
    input wire doRet,
    // Controller side
    output reg coreAcceptReady,
    output reg returnFromIrq
);
    reg [1:0] phase_q;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 2'h0;
            coreAcceptReady <= 1'b0;
            returnFromIrq <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            // A slow core grants one cycle in four, so a take may wait
            coreAcceptReady <= !slow || phase_q == 2'h3;
            returnFromIrq <= doRet;
        end
    end
endmodule

/* File: bench/fvic_controller_asserts.sv */
// Checker for the interrupt controller, bound to its ports.
// Assumes one clock domain with the core reset.
`timescale 1ns/10ps
module fvic_controller_asserts (
    // Clock and reset
    input wire clock,
    input wire reset_n,
    // Watched ports
    input wire regRead,
    input wire [7:0] regRdData_q,
    input wire returnFromIrq,
    input wire irqTake_q,
    input wire [15:0] vectorAddr_q,
    input wire pushReturn_q,
    input wire popReturn_q,
    input wire globalIrqDisable_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_TAKE_DISABLES: assert property (irqTake_q |-> globalIrqDisable_q)
        else $error("take left global disable clear");
    AST_NO_TAKE_DIS: assert property (irqTake_q |-> !$past(globalIrqDisable_q))
        else $error("take while globally disabled");
    AST_TAKE_ONE: assert property (irqTake_q |=> !irqTake_q)
        else $error("take longer than one cycle");
    AST_PUSH_TAKE: assert property (pushReturn_q |-> irqTake_q && vectorAddr_q != 16'h0000)
        else $error("push without vectored take");
    AST_RESET_BRANCH: assert property (irqTake_q && !pushReturn_q |-> vectorAddr_q == 16'h0000)
        else $error("unpushed take not to reset address");
    AST_VEC_LEGAL: assert property (irqTake_q |-> vectorAddr_q inside
        {16'h0000, 16'h0008, 16'h0010, 16'h0018, 16'h0020})
        else $error("illegal vector");
    AST_RET_POP: assert property (returnFromIrq |=> popReturn_q && !globalIrqDisable_q)
        else $error("return did not pop and enable");
    AST_VEC_HOLD: assert property (!irqTake_q |-> $stable(vectorAddr_q))
        else $error("vector moved without take");
    AST_RD_QUIET: assert property (!$past(regRead) |-> regRdData_q == 8'h00)
        else $error("read data outside read slot");
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the interrupt controller with a core model.
// Assumes a 20 MHz clock; pins are driven on clock edges.
`timescale 1ns/10ps
module tb_top;
    reg clock, reset_n, regWrite, regRead, extPin, tclkPin, extSel, tclkSel;
    reg wide, capSel, portMis, txEmpty, rxFull, slow, doRet;
    reg [7:0] regAddr, regWrData, evs;
    reg [17:0] tab [0:9];
    wire [7:0] rdData;
    wire [15:0] vec;
    wire take, push, pop, gid, ready, ret;
    integer error_cnt, checked, i, j;
    fvic_controller dut_u (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData_q(rdData),
        .extIrqPin(extPin), .timerClockPin(tclkPin), .extPinEdgeSelect(extSel),
        .timerClockEdgeSelect(tclkSel), .timerZeroOverflow(evs[0]), .timerOneRollover8(evs[1]),
        .timerOneTwoRollover16(evs[2]), .timerOneWideMode(wide), .timerTwoRollover(evs[3]),
        .timerThreeOverflow(evs[4]), .timerThreePeriodRollover(evs[5]), .captureOneSelect(capSel),
        .captureOneEvent(evs[6]), .captureTwoEvent(evs[7]), .portMismatch(portMis),
        .transmitEmpty(txEmpty), .receiveFull(rxFull), .coreAcceptReady(ready),
        .returnFromIrq(ret), .irqTake_q(take), .vectorAddr_q(vec), .pushReturn_q(push),
        .popReturn_q(pop), .globalIrqDisable_q(gid));
    fvic_core_model core_u (.clock(clock), .reset_n(reset_n), .slow(slow), .doRet(doRet),
        .coreAcceptReady(ready), .returnFromIrq(ret));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clock);
            regAddr <= a;
            regWrData <= d;
            regWrite <= 1'b1;
            @(posedge clock);
            regWrite <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] m, input [7:0] e);
        begin
            @(posedge clock);
            regAddr <= a;
            regRead <= 1'b1;
            @(posedge clock);
            regRead <= 1'b0;
            #1;
            chk("regRead", e, rdData & m);
        end
    endtask
    task pulse(input [7:0] m);
        begin
            @(posedge clock);
            evs <= m;
            @(posedge clock);
            evs <= 8'h00;
        end
    endtask
    task pins(input e, input t, input [7:0] x);
        begin
            @(posedge clock);
            extPin <= e;
            tclkPin <= t;
            repeat (6) @(posedge clock);
            rd(8'h07, 8'h50, x);
        end
    endtask
    // All ones means no take is expected within the wait
    task waitTake(input [15:0] e);
        begin
            #1;
            for (i = 0; i < 30 && take !== 1'b1; i = i + 1) begin
                @(posedge clock) #1;
            end
            if (e === 16'hffff)
                chk("noTake", 16'h0000, take);
            else
                chk("vector", e, vec);
        end
    endtask
    task retIrq;
        begin
            @(posedge clock);
            doRet <= 1'b1;
            @(posedge clock);
            doRet <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask
    task summarize;
        begin
            $display("Checks %0d, errors %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Generous against the few hundred cycles the sequence needs
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        summarize;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        error_cnt = 0;
        checked = 0;
        {regWrite, regRead, extPin, extSel, wide, capSel, portMis, rxFull, slow, doRet} = 10'h000;
        {tclkPin, tclkSel, txEmpty} = 3'h7;
        regAddr = 8'h00;
        regWrData = 8'h00;
        evs = 8'h00;
        tab = '{18'h0_0210, 18'h0_0400, 18'h2_0410, 18'h2_0200, 18'h0_0820,
            18'h1_1040, 18'h1_2000, 18'h0_2040, 18'h0_1000, 18'h0_8008};
        reset_n = 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        chk("disable", 16'h0001, gid);
        rd(8'h07, 8'hff, 8'h00);
        rd(8'h16, 8'hff, 8'h02);
        rd(8'h06, 8'h10, 8'h10);
        rd(8'h20, 8'hff, 8'h00);
        wr(8'h17, 8'hff);
        rd(8'h17, 8'hff, 8'hff);
        wr(8'h17, 8'h04);
        pins(1'b1, 1'b0, 8'h00);
        pins(1'b0, 1'b1, 8'h50);
        pulse(8'h01);
        rd(8'h07, 8'h70, 8'h70);
        pulse(8'h40);
        rd(8'h07, 8'h80, 8'h80);
        wr(8'h17, 8'h00);
        rd(8'h07, 8'h80, 8'h00);
        wr(8'h17, 8'h04);
        wr(8'h07, 8'h7f);
        waitTake(16'hffff);
        slow <= 1'b1;
        wr(8'h06, 8'h00);
        waitTake(16'h0008);
        retIrq;
        waitTake(16'h0010);
        retIrq;
        waitTake(16'h0018);
        retIrq;
        waitTake(16'h0020);
        rd(8'h07, 8'h70, 8'h00);
        rd(8'h16, 8'h04, 8'h04);
        wr(8'h16, 8'h00);
        wr(8'h07, 8'h07);
        pulse(8'h40);
        retIrq;
        waitTake(16'hffff);
        chk("disable", 16'h0000, gid);
        slow <= 1'b0;
        @(posedge clock);
        regAddr <= 8'h07;
        regWrData <= 8'h05;
        regWrite <= 1'b1;
        evs <= 8'h01;
        @(posedge clock);
        regWrite <= 1'b0;
        evs <= 8'h00;
        waitTake(16'h0000);
        chk("push", 16'h0000, push);
        retIrq;
        wr(8'h06, 8'h10);
        rd(8'h06, 8'h10, 8'h10);
        wr(8'h16, 8'h00);
        for (j = 0; j < 10; j = j + 1) begin
            wide <= tab[j][17];
            capSel <= tab[j][16];
            pulse(tab[j][15:8]);
            rd(8'h16, 8'hfc, tab[j][7:0]);
            wr(8'h16, 8'h00);
        end
        portMis <= 1'b1;
        wr(8'h16, 8'h00);
        rd(8'h16, 8'h80, 8'h80);
        portMis <= 1'b0;
        wr(8'h16, 8'h00);
        rd(8'h16, 8'h80, 8'h00);
        txEmpty <= 1'b0;
        rxFull <= 1'b1;
        rd(8'h16, 8'h03, 8'h01);
        summarize;
    end
endmodule
bind fvic_controller fvic_controller_asserts chk_u (.clock, .reset_n, .regRead, .regRdData_q,
    .returnFromIrq, .irqTake_q, .vectorAddr_q, .pushReturn_q, .popReturn_q, .globalIrqDisable_q);
